// file: asc_clk_div.sv
// Converter clock divider producing one tick per divided period
`timescale 1ns/1ps
module asc_clk_div
	import asc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic [1:0] clk_sel,
	output logic            tick
);
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic       tick_reg;
	logic       tick_next;

	// Wrap on reaching or passing the limit, so a smaller divisor never stalls
	always_comb begin
		cnt_next  = cnt_reg + 5'h01;
		tick_next = 1'b0;
		if (cnt_reg >= asc_div_lim(clk_sel)) begin
			cnt_next  = 5'h00;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_reg  <= 5'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// file: asc_conv_timer.sv
// Conversion length counter, held in reset while the start bit is high
`timescale 1ns/1ps
module asc_conv_timer
	import asc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic hold,
	input  wire logic launch,
	input  wire logic tick,
	output logic      busy,
	output logic      done
);
	logic       busy_reg;
	logic       busy_next;
	logic       done_reg;
	logic       done_next;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;

	// Hold wins over everything; a launch restarts the count
	always_comb begin
		busy_next = busy_reg;
		done_next = 1'b0;
		cnt_next  = cnt_reg;
		if (hold) begin
			busy_next = 1'b0;
			cnt_next  = 5'h00;
		end else if (launch) begin
			busy_next = 1'b1;
			cnt_next  = 5'h00;
		end else if (busy_reg && tick) begin
			cnt_next = cnt_reg + 5'h01;
			if (cnt_reg == ASC_CONV_TICKS - 5'h01) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			cnt_reg  <= 5'h00;
		end else begin
			busy_reg <= busy_next;
			done_reg <= done_next;
			cnt_reg  <= cnt_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule

// file: asc_pkg.sv
// Shared constants, register map and field layouts of the conversion sequencer
package asc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] ASC_IDX_RESULT = 8'h21;
	localparam logic [7:0] ASC_IDX_CTRL   = 8'h22;
	localparam logic [7:0] ASC_IDX_CLKSET = 8'h23;
	localparam logic [7:0] ASC_IDX_INTST  = 8'h24;
	localparam logic [7:0] ASC_IDX_INTMSK = 8'h25;

	// Field positions
	localparam int ASC_CTRL_CHAN_LSB = 0;
	localparam int ASC_CTRL_PIN_LSB  = 3;
	localparam int ASC_CTRL_PEND_BIT = 6;
	localparam int ASC_CTRL_START    = 7;
	localparam int ASC_CLK_SEL_LSB   = 0;
	localparam int ASC_CLK_CMP_BIT   = 2;
	localparam int ASC_CLK_TEST_BIT  = 7;
	localparam int ASC_INT_DONE_BIT  = 0;

	// Reset values
	localparam logic [7:0] ASC_CTRL_RST   = 8'h00;
	localparam logic [7:0] ASC_CLKSET_RST = 8'h00;
	localparam logic [7:0] ASC_INT_RST    = 8'h00;

	// Converter clock divisors minus one, and conversion length in converter clocks
	localparam logic [4:0] ASC_DIV2_LIM  = 5'h01;
	localparam logic [4:0] ASC_DIV8_LIM  = 5'h07;
	localparam logic [4:0] ASC_DIV32_LIM = 5'h1f;
	localparam logic [4:0] ASC_CONV_TICKS = 5'h10;

	// Control register layout
	typedef struct packed {
		logic       start;
		logic       pending;
		logic [2:0] pin_cfg;
		logic [2:0] chan;
	} asc_ctrl_t;

	// Clock-setting register layout
	typedef struct packed {
		logic       test;
		logic [3:0] unused;
		logic       cmp_en;
		logic [1:0] clk_sel;
	} asc_clkset_t;

	// Lowest n pins analog for n below 7, all eight for 7
	function automatic logic [7:0] asc_pin_mask(input logic [2:0] cfg);
		if (cfg == 3'h7) begin
			return 8'hff;
		end
		return (8'h01 << cfg) - 8'h01;
	endfunction

	// Divider terminal count per clock select; select 11 behaves as /32
	function automatic logic [4:0] asc_div_lim(input logic [1:0] sel);
		case (sel)
			2'h0: return ASC_DIV2_LIM;
			2'h1: return ASC_DIV8_LIM;
			default: return ASC_DIV32_LIM;
		endcase
	endfunction

endpackage

// file: asc_top.sv
// Conversion sequencer control: APB registers, pin config, start and completion
// Summary of operation
// (RQ1) Channel field bits 2..0 route analog input n to the converter.
// (RQ2) Pin config n makes lowest n port B pins analog; 7 makes all.
// (RQ3) Analog-configured port B pins lose digital path and pull-up.
// (RQ4) Control bit 6 reads 1 while a conversion is outstanding, else 0.
// (RQ5) Start bit high holds converter in reset and forces the flag to 1.
// (RQ6) Start falling from 1 to 0 launches a conversion on the channel.
// (RQ7) Software selects channel first, then writes start 0, 1, 0.
// (RQ8) Software keeps start low until the pending flag clears.
// (RQ9) Completion clears the flag and raises the interrupt request.
// (RQ10) Each 8-bit outcome lands in the result register.
// (RQ11) Start reads 0 after reset.
// (RQ12) Clock select 00, 01, 10 give sys/2, /8, /32; 11 not used.
// (RQ13) Clock-setting bit 2 enables the comparator; 0 during reset.
// (RQ14) Clock-setting bit 7 is test only and must stay 0.
// (RQ15) Software clears start and pin config before stop state.
// (RQ16) Conversion lasts fixed converter clocks; clock bits 3..6 read 0.
`timescale 1ns/1ps
module asc_top
	import asc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  conv_data,
	output logic [2:0]       analog_select,
	output logic             conv_reset,
	output logic             conv_launch,
	output logic             conv_clk_tick,
	output logic [7:0]       pb_analog_mask,
	output logic [7:0]       pb_io_disable,
	output logic [7:0]       pb_pullup_disable,
	output logic             comparator_enable,
	output logic             test_mode,
	output logic             irq
);
	asc_ctrl_t   ctrl_reg;
	asc_ctrl_t   ctrl_next;
	asc_clkset_t clk_reg;
	asc_clkset_t clk_next;
	logic [7:0]  result_reg;
	logic [7:0]  result_next;
	logic [7:0]  intst_reg;
	logic [7:0]  intst_next;
	logic [7:0]  intmsk_reg;
	logic [7:0]  intmsk_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pready_reg;
	logic        pready_next;
	logic        pslverr_reg;
	logic        pslverr_next;
	logic [2:0]  sel_reg;
	logic        creset_reg;
	logic        claunch_reg;
	logic        ctick_reg;
	logic [7:0]  pmask_reg;
	logic        cmp_reg;
	logic        test_reg;
	logic        irq_reg;
	logic        wr_en;
	logic        launch;
	logic        tick;
	logic        busy;
	logic        done;
	logic [7:0]  idx;
	logic        mapped;

	// Word index from byte address; low two bits must be zero
	assign idx    = paddr[9:2];
	assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
		(idx >= ASC_IDX_RESULT) && (idx <= ASC_IDX_INTMSK);
	assign wr_en  = psel && penable && pready_reg && pwrite && mapped;

	asc_clk_div i_asc_clk_div (
		.sys_clk (sys_clk),
		.srst    (srst),
		.clk_sel (clk_reg.clk_sel),
		.tick    (tick)
	);

	// Hold follows the start value being written: the stored bit is still high
	// in the launch cycle and would otherwise swallow every launch
	asc_conv_timer i_asc_conv_timer (
		.sys_clk (sys_clk),
		.srst    (srst),
		.hold    (ctrl_next.start),
		.launch  (launch),
		.tick    (tick),
		.busy    (busy),
		.done    (done)
	);

	// Register next values; pending is owned by hardware, not by writes
	always_comb begin
		ctrl_next   = ctrl_reg;
		clk_next    = clk_reg;
		result_next = result_reg;
		intst_next  = intst_reg;
		intmsk_next = intmsk_reg;
		if (wr_en && idx == ASC_IDX_CTRL) begin
			ctrl_next.chan    = pwdata[ASC_CTRL_CHAN_LSB +: 3];
			ctrl_next.pin_cfg = pwdata[ASC_CTRL_PIN_LSB +: 3];
			ctrl_next.start   = pwdata[ASC_CTRL_START];
		end
		// (RQ16) unused bits stay zero
		if (wr_en && idx == ASC_IDX_CLKSET) begin
			clk_next.clk_sel = pwdata[ASC_CLK_SEL_LSB +: 2];
			clk_next.cmp_en  = pwdata[ASC_CLK_CMP_BIT];
			clk_next.test    = pwdata[ASC_CLK_TEST_BIT];
			clk_next.unused  = 4'h0;
		end
		if (wr_en && idx == ASC_IDX_INTMSK) begin
			intmsk_next = pwdata[7:0];
		end
		if (wr_en && idx == ASC_IDX_INTST) begin
			intst_next = intst_reg & ~pwdata[7:0];
		end
		// (RQ9) done sets status, winning over a clear
		if (done) begin
			intst_next[ASC_INT_DONE_BIT] = 1'b1;
		end
		// (RQ10) capture outcome at completion
		if (done) begin
			result_next = conv_data;
		end
		// (RQ5) start high forces pending; (RQ4) completion clears it
		if (ctrl_next.start) begin
			ctrl_next.pending = 1'b1;
		end else if (done) begin
			ctrl_next.pending = 1'b0;
		end
	end

	// (RQ6) falling start launches a conversion
	assign launch = ctrl_reg.start && !ctrl_next.start;

	// (RQ11) start and (RQ13) comparator enable clear at reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_reg   <= ASC_CTRL_RST;
			clk_reg    <= ASC_CLKSET_RST;
			result_reg <= 8'h00;
			intst_reg  <= ASC_INT_RST;
			intmsk_reg <= ASC_INT_RST;
		end else begin
			ctrl_reg   <= ctrl_next;
			clk_reg    <= clk_next;
			result_reg <= result_next;
			intst_reg  <= intst_next;
			intmsk_reg <= intmsk_next;
		end
	end

	// APB answer: ready in the first access cycle, zero wait states
	always_comb begin
		pready_next  = psel && !penable;
		pslverr_next = psel && !penable && !mapped;
		prdata_next  = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (idx)
				ASC_IDX_RESULT: prdata_next[7:0] = result_reg;
				ASC_IDX_CTRL:   prdata_next[7:0] = ctrl_reg;
				ASC_IDX_CLKSET: prdata_next[7:0] = clk_reg;
				ASC_IDX_INTST:  prdata_next[7:0] = intst_reg;
				ASC_IDX_INTMSK: prdata_next[7:0] = intmsk_reg;
				default:        prdata_next = 32'h0000_0000;
			endcase
			if (!mapped) begin
				prdata_next = 32'h0000_0000;
			end
		end
	end

	// Outputs registered so the pads and core see glitch-free levels
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			sel_reg     <= 3'h0;
			creset_reg  <= 1'b0;
			claunch_reg <= 1'b0;
			ctick_reg   <= 1'b0;
			pmask_reg   <= 8'h00;
			cmp_reg     <= 1'b0;
			test_reg    <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			// (RQ1) channel routing
			sel_reg     <= ctrl_reg.chan;
			// (RQ5) converter reset level
			creset_reg  <= ctrl_reg.start;
			claunch_reg <= launch;
			// (RQ12) divided converter clock
			ctick_reg   <= tick;
			// (RQ2) pin analog mask
			pmask_reg   <= asc_pin_mask(ctrl_reg.pin_cfg);
			cmp_reg     <= clk_reg.cmp_en;
			// (RQ14) test bit passed out only
			test_reg    <= clk_reg.test;
			irq_reg     <= |(intst_reg & intmsk_reg);
		end
	end

	assign prdata            = prdata_reg;
	assign pready            = pready_reg;
	assign pslverr           = pslverr_reg;
	assign analog_select     = sel_reg;
	assign conv_reset        = creset_reg;
	assign conv_launch       = claunch_reg;
	assign conv_clk_tick     = ctick_reg;
	assign pb_analog_mask    = pmask_reg;
	// (RQ3) analog pins lose digital path and pull-up
	assign pb_io_disable     = pmask_reg;
	assign pb_pullup_disable = pmask_reg;
	assign comparator_enable = cmp_reg;
	assign test_mode         = test_reg;
	assign irq               = irq_reg;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	property p_chan_route;
		claunch_reg |=> analog_select == $past(ctrl_reg.chan);
	endproperty
	a_chan_route: assert property (p_chan_route) else $error("channel not routed"); // RQ1

	property p_pin_mask;
		ctrl_reg.pin_cfg == 3'h7 ##1 ctrl_reg.pin_cfg == 3'h7 |-> pb_analog_mask == 8'hff;
	endproperty
	a_pin_mask: assert property (p_pin_mask) else $error("pin config 7 not all analog"); // RQ2

	property p_pin_low;
		ctrl_reg.pin_cfg == 3'h3 ##1 ctrl_reg.pin_cfg == 3'h3 |-> pb_pullup_disable == 8'h07;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin config 3 wrong mask"); // RQ3

	property p_pend_clear;
		done && !ctrl_next.start |=> !ctrl_reg.pending;
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared"); // RQ4

	property p_start_hold;
		ctrl_reg.start |-> ctrl_reg.pending ##1 conv_reset;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start high not held"); // RQ5

	property p_launch;
		$fell(ctrl_reg.start) |-> conv_launch ##1 busy ##1 !conv_launch;
	endproperty
	a_launch: assert property (p_launch) else $error("fall did not launch"); // RQ6

	property p_irq;
		done && intmsk_reg[ASC_INT_DONE_BIT] |=> intst_reg[ASC_INT_DONE_BIT] ##1 irq;
	endproperty
	a_irq: assert property (p_irq) else $error("done did not raise interrupt"); // RQ9

	property p_result;
		done |=> result_reg == $past(conv_data);
	endproperty
	a_result: assert property (p_result) else $error("result not captured"); // RQ10

	property p_reset_start;
		disable iff (1'b0) srst |=> !ctrl_reg.start && !comparator_enable;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("reset left start set"); // RQ11

	property p_div2;
		clk_reg.clk_sel == 2'h0 && tick ##1 clk_reg.clk_sel == 2'h0 [*3] |-> !tick ##1 tick;
	endproperty
	a_div2: assert property (p_div2) else $error("sys/2 tick spacing wrong"); // RQ12

	property p_cmp;
		$rose(clk_reg.cmp_en) |=> comparator_enable;
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator enable not followed"); // RQ13

	property p_unused;
		pready_reg && !pwrite && idx == ASC_IDX_CLKSET && mapped |-> prdata[6:3] == 4'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("clock bits 3..6 not zero"); // RQ16

	property p_tick_out;
		tick |=> conv_clk_tick ##1 !conv_clk_tick;
	endproperty
	a_tick_out: assert property (p_tick_out) else $error("converter tick not passed out"); // RQ12

	property p_io_off;
		ctrl_reg.pin_cfg == 3'h0 ##1 ctrl_reg.pin_cfg == 3'h0 |-> pb_io_disable == 8'h00;
	endproperty
	a_io_off: assert property (p_io_off) else $error("pin config 0 disabled a pin"); // RQ3

	property p_abort;
		ctrl_reg.start |-> !done;
	endproperty
	a_abort: assert property (p_abort) else $error("completion while start held"); // RQ5
endmodule

// file: asc_top_bench.sv
// Self-checking bench for the conversion sequencer control block
`timescale 1ns/1ps
module asc_top_bench;
	import asc_pkg::*;
	logic        sys_clk, srst, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, conv_reset, conv_launch, conv_clk_tick;
	logic [7:0]  conv_data, pb_analog_mask, pb_io_disable, pb_pullup_disable;
	logic [2:0]  analog_select;
	logic        comparator_enable, test_mode, irq;
	logic [32:0] exp_q[$];
	int          mismatches, n_tests;
	logic [2:0]  ch;
	logic [7:0]  m;

	asc_top i_asc_top (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_data(conv_data), .analog_select(analog_select),
		.conv_reset(conv_reset), .conv_launch(conv_launch), .conv_clk_tick(conv_clk_tick),
		.pb_analog_mask(pb_analog_mask), .pb_io_disable(pb_io_disable),
		.pb_pullup_disable(pb_pullup_disable), .comparator_enable(comparator_enable),
		.test_mode(test_mode), .irq(irq));

	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (mismatches == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		n_tests++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// One APB transfer; reads leave their expectation in the queue
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic [32:0] want);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		if (!wr) begin
			exp_q.push_back(want);
		end
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			check(1'b0, 1'b1);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Registered outputs settle one edge after the write lands
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// Read results compared against the oldest note
	always @(posedge sys_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			check({pslverr, prdata}, exp_q.pop_front());
		end
	end

	// Full conversion; msk selects whether the interrupt may show
	task automatic conv(input logic [1:0] sel, input logic msk, input logic abort);
		int div, k, t;
		logic [7:0] d;
		div = (sel == 2'h0) ? 2 : (sel == 2'h1) ? 8 : 32;
		t = int'(ASC_CONV_TICKS);
		ch = 3'($urandom % 8);
		d = 8'($urandom);
		conv_data <= d;
		apb(1'b1, ba(ASC_IDX_CLKSET), {6'h00, sel}, 33'h0);
		apb(1'b1, ba(ASC_IDX_INTMSK), {7'h00, msk}, 33'h0);
		apb(1'b1, ba(ASC_IDX_CTRL), {5'h10, ch}, 33'h0);
		apb(1'b0, ba(ASC_IDX_CTRL), 8'h00, {25'h0, 5'h18, ch});
		settle();
		check(conv_reset, 1'b1);
		// converter tick spacing, every sample taken at an edge
		do begin
			@(posedge sys_clk);
		end while (conv_clk_tick !== 1'b1);
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (conv_clk_tick !== 1'b1 && k < 40);
		check(k, div);
		apb(1'b1, ba(ASC_IDX_CTRL), {5'h00, ch}, 33'h0);
		#1;
		check(conv_launch, 1'b1);
		if (abort) begin
			repeat (8) @(posedge sys_clk);
			apb(1'b1, ba(ASC_IDX_CTRL), {5'h10, ch}, 33'h0);
			repeat (600) @(posedge sys_clk);
			check(irq, 1'b0);
			apb(1'b0, ba(ASC_IDX_INTST), 8'h00, 33'h0);
			apb(1'b0, ba(ASC_IDX_CTRL), 8'h00, {25'h0, 5'h18, ch});
			apb(1'b1, ba(ASC_IDX_CTRL), {5'h00, ch}, 33'h0);
		end
		k = 0;
		while (irq !== 1'b1 && k < 16 * div + div + 10) begin
			@(posedge sys_clk);
			k++;
		end
		if (msk) begin
			// Last tick lands after t-1 full periods plus the phase; status, irq, late sample
			check(k >= (t - 1) * div + 4 && k <= t * div + 3, 1'b1);
		end else begin
			check(irq, 1'b0);
		end
		apb(1'b0, ba(ASC_IDX_CTRL), 8'h00, {25'h0, 5'h00, ch});
		apb(1'b0, ba(ASC_IDX_RESULT), 8'h00, {25'h0, d});
		apb(1'b1, ba(ASC_IDX_RESULT), 8'h5a, 33'h0);
		apb(1'b0, ba(ASC_IDX_RESULT), 8'h00, {25'h0, d});
		apb(1'b0, ba(ASC_IDX_INTST), 8'h00, 33'h1);
		apb(1'b1, ba(ASC_IDX_INTST), 8'h01, 33'h0);
		settle();
		check(irq, 1'b0);
	endtask

	// Watchdog
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, conv_data} = '0;
		srst = 1'b1;
		mismatches = 0;
		n_tests = 0;
		void'($urandom(41));
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		apb(1'b0, ba(ASC_IDX_CTRL), 8'h00, 33'h0);
		apb(1'b0, ba(ASC_IDX_CLKSET), 8'h00, 33'h0);
		apb(1'b0, ba(ASC_IDX_INTMSK), 8'h00, 33'h0);
		apb(1'b1, ba(ASC_IDX_CLKSET), 8'h7d, 33'h0);
		apb(1'b0, ba(ASC_IDX_CLKSET), 8'h00, 33'h5);
		settle();
		check({comparator_enable, test_mode}, 2'b10);
		apb(1'b0, 12'h089, 8'h00, {1'b1, 32'h0});
		apb(1'b0, ba(8'h26), 8'h00, {1'b1, 32'h0});
		for (int n = 0; n < 8; n++) begin
			ch = 3'($urandom % 8);
			apb(1'b1, ba(ASC_IDX_CTRL), {2'b00, 3'(n), ch}, 33'h0);
			settle();
			m = (n == 7) ? 8'hff : 8'((9'h001 << n) - 9'h001);
			check(pb_analog_mask, m);
			check({pb_io_disable, pb_pullup_disable}, {m, m});
			check(analog_select, ch);
		end
		conv(2'h0, 1'b1, 1'b0);
		conv(2'h1, 1'b1, 1'b0);
		conv(2'h2, 1'b1, 1'b0);
		conv(2'h0, 1'b0, 1'b0);
		conv(2'h1, 1'b1, 1'b1);
		apb(1'b1, ba(ASC_IDX_CTRL), 8'h00, 33'h0);
		settle();
		check({conv_reset, pb_analog_mask}, 9'h000);
		complete_run();
	end
endmodule
